// File: sjtap_regs.svh
`ifndef SJTAP_REGS_SVH
`define SJTAP_REGS_SVH
// What this block does
// - Test inputs sampled on rising test clock; serial out launched on falling edge.
// - Mode select alone steers the port state machine on each rising edge.
// - Serial path chosen from current state plus the held instruction.
// - Serial in feeds the selected register; serial out shows its far end.
// - No test reset pin; only mode-select sequence or power-up resets the port.
// - Mode select high for five rising edges reaches Test-Logic-Reset from anywhere.
// - Power-up forces the reset state regardless of test clock or mode select.
// - Undriven serial in or mode select reads as logic 1.
// - Register lengths: instruction 3, bypass 1, identification 32, pin chain 109.
// - Identification instruction loaded at power-up and in Test-Logic-Reset.
// - Codes 000 ext, 001 id, 010 sample-float, 100 sample, 111 bypass.
// - Sample-float holds memory outputs high impedance and scans the pin chain.
// - Bypass instruction puts the one-bit bypass register in the path.

`define SJTAP_IR_LEN 3
`define SJTAP_ID_LEN 32
`define SJTAP_PIN_LEN 109
`define SJTAP_IR_CAPTURE 3'h1
`define SJTAP_BYPASS_CAPTURE 1'h0
`define SJTAP_TDO_RESET 1'h0
`endif

// File: sjtap_pkg.sv
package sjtap_pkg;
   typedef enum logic [3:0] {
      SJTAP_TLR = 4'hf,
      SJTAP_RTI = 4'hc,
      SJTAP_SEL_DR = 4'h7,
      SJTAP_CAP_DR = 4'h6,
      SJTAP_SH_DR = 4'h2,
      SJTAP_EX1_DR = 4'h1,
      SJTAP_PAU_DR = 4'h3,
      SJTAP_EX2_DR = 4'h0,
      SJTAP_UPD_DR = 4'h5,
      SJTAP_SEL_IR = 4'h4,
      SJTAP_CAP_IR = 4'he,
      SJTAP_SH_IR = 4'ha,
      SJTAP_EX1_IR = 4'h9,
      SJTAP_PAU_IR = 4'hb,
      SJTAP_EX2_IR = 4'h8,
      SJTAP_UPD_IR = 4'hd
   } sjtap_state_t;

   typedef enum logic [2:0] {
      SJTAP_I_EXTEST = 3'h0,
      SJTAP_I_IDCODE = 3'h1,
      SJTAP_I_SAMPLE_Z = 3'h2,
      SJTAP_I_RSV3 = 3'h3,
      SJTAP_I_SAMPLE = 3'h4,
      SJTAP_I_RSV5 = 3'h5,
      SJTAP_I_RSV6 = 3'h6,
      SJTAP_I_BYPASS = 3'h7
   } sjtap_instr_t;

   typedef enum logic [1:0] {
      SJTAP_DR_BYPASS = 2'h0,
      SJTAP_DR_ID = 2'h1,
      SJTAP_DR_PINS = 2'h2
   } sjtap_dr_sel_t;
endpackage

// File: sjtap_tap_if.sv
`timescale 1ns/1ps
interface sjtap_tap_if;
   import sjtap_pkg::*;
   logic rst;
   logic run;
   sjtap_state_t state;
   modport fsm (input rst, input run, output state);
   modport dp (output rst, output run, input state);
endinterface

// File: sjtap_fsm.sv
`timescale 1ns/1ps
module sjtap_fsm (
   input wire logic tck,       // Test clock from the scan controller
   input wire logic tms,       // Mode select, high when undriven
   sjtap_tap_if.fsm tap        // State out, reset and run in
);
   import sjtap_pkg::*;

   sjtap_state_t next_state;

   // =====================================================
   // Sixteen-state sequencer
   always_comb begin
      next_state = tap.state;
      unique case (tap.state)
         SJTAP_TLR: next_state = tms ? SJTAP_TLR : SJTAP_RTI;
         SJTAP_RTI: next_state = tms ? SJTAP_SEL_DR : SJTAP_RTI;
         SJTAP_SEL_DR: next_state = tms ? SJTAP_SEL_IR : SJTAP_CAP_DR;
         SJTAP_CAP_DR: next_state = tms ? SJTAP_EX1_DR : SJTAP_SH_DR;
         SJTAP_SH_DR: next_state = tms ? SJTAP_EX1_DR : SJTAP_SH_DR;
         SJTAP_EX1_DR: next_state = tms ? SJTAP_UPD_DR : SJTAP_PAU_DR;
         SJTAP_PAU_DR: next_state = tms ? SJTAP_EX2_DR : SJTAP_PAU_DR;
         SJTAP_EX2_DR: next_state = tms ? SJTAP_UPD_DR : SJTAP_SH_DR;
         SJTAP_UPD_DR: next_state = tms ? SJTAP_SEL_DR : SJTAP_RTI;
         SJTAP_SEL_IR: next_state = tms ? SJTAP_TLR : SJTAP_CAP_IR;
         SJTAP_CAP_IR: next_state = tms ? SJTAP_EX1_IR : SJTAP_SH_IR;
         SJTAP_SH_IR: next_state = tms ? SJTAP_EX1_IR : SJTAP_SH_IR;
         SJTAP_EX1_IR: next_state = tms ? SJTAP_UPD_IR : SJTAP_PAU_IR;
         SJTAP_PAU_IR: next_state = tms ? SJTAP_EX2_IR : SJTAP_PAU_IR;
         SJTAP_EX2_IR: next_state = tms ? SJTAP_UPD_IR : SJTAP_SH_IR;
         SJTAP_UPD_IR: next_state = tms ? SJTAP_SEL_DR : SJTAP_RTI;
      endcase
   end

   // Every path reaches reset within five high mode-select edges
   always_ff @(posedge tck or posedge tap.rst) begin
      if (tap.rst) begin
         tap.state <= SJTAP_TLR;
      end else if (tap.run) begin
         tap.state <= next_state;
      end
   end
endmodule

// File: sjtap_top.sv
`timescale 1ns/1ps
`include "sjtap_regs.svh"
module sjtap_top #(
   parameter logic [`SJTAP_ID_LEN-1:0] ID_CODE = 32'h0000_0001, // Arbitrary value
   parameter int PIN_LEN = `SJTAP_PIN_LEN
) (
   input wire logic sys_clk,                // Memory core clock
   input wire logic rst_b,                  // Power-up reset, sync, active low
   input wire logic clk_en,                 // Freezes all state but the pin samplers and the enable synchronizer while low
   input wire logic tck,                    // Test clock, link domain
   input wire logic tms,                    // Mode select
   input wire logic tdi,                    // Serial data in
   input wire logic [PIN_LEN:1] pin_state,  // Pin levels seen by the chain
   output logic tdo,                        // Serial data out
   output logic tdo_oe_n,                   // Low while tdo is driven
   output logic out_float,                  // Memory outputs to high impedance
   output logic extest_drive,               // Drive pins from scan data
   output logic [PIN_LEN:1] pin_drive       // Scan data for output pins
);
   import sjtap_pkg::*;

   sjtap_tap_if tap ();

   // =====================================================
   // Core domain power-up hold
   logic por_hold;

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         por_hold <= 1'b1;
      end else if (clk_en) begin
         por_hold <= 1'b0;
      end
   end

   // Reset reaches the test logic without a test clock edge
   assign tap.rst = por_hold;

   // =====================================================
   // Clock enable into the test domain
   logic en_meta;
   logic en_t;

   always_ff @(posedge tck or posedge tap.rst) begin
      if (tap.rst) begin
         en_meta <= 1'b0;
         en_t <= 1'b0;
      end else begin
         en_meta <= clk_en;
         en_t <= en_meta;
      end
   end

   assign tap.run = en_t;

   sjtap_fsm u_fsm (
      .tck (tck),
      .tms (tms),
      .tap (tap)
   );

   // =====================================================
   // Instruction register
   logic [`SJTAP_IR_LEN-1:0] ir_shift;
   sjtap_instr_t instr;

   always_ff @(posedge tck or posedge tap.rst) begin
      if (tap.rst) begin
         ir_shift <= `SJTAP_IR_CAPTURE;
      end else if (en_t) begin
         if (tap.state == SJTAP_CAP_IR) begin
            ir_shift <= `SJTAP_IR_CAPTURE;
         end else if (tap.state == SJTAP_SH_IR) begin
            ir_shift <= {tdi, ir_shift[`SJTAP_IR_LEN-1:1]};
         end
      end
   end

   always_ff @(posedge tck or posedge tap.rst) begin
      if (tap.rst) begin
         instr <= SJTAP_I_IDCODE;
      end else if (en_t) begin
         if (tap.state == SJTAP_TLR) begin
            instr <= SJTAP_I_IDCODE;
         end else if (tap.state == SJTAP_UPD_IR) begin
            instr <= sjtap_instr_t'(ir_shift);
         end
      end
   end

   // =====================================================
   // Data register selection
   // Reserved codes fall back to bypass so the chain length stays defined
   sjtap_dr_sel_t dr_sel;

   always_comb begin
      unique case (instr)
         SJTAP_I_IDCODE: dr_sel = SJTAP_DR_ID;
         SJTAP_I_EXTEST, SJTAP_I_SAMPLE_Z, SJTAP_I_SAMPLE: dr_sel = SJTAP_DR_PINS;
         default: dr_sel = SJTAP_DR_BYPASS;
      endcase
   end

   // =====================================================
   // Data registers
   logic single_bit_bypass_reg;
   logic [`SJTAP_ID_LEN-1:0] id_shift;
   logic [PIN_LEN:1] pin_scan_chain;
   logic [PIN_LEN:1] pin_meta;
   logic [PIN_LEN:1] pin_sync;
   logic cap_dr;
   logic sh_dr;

   assign cap_dr = en_t && tap.state == SJTAP_CAP_DR;
   assign sh_dr = en_t && tap.state == SJTAP_SH_DR;

   // Pin levels come from the core clock; results are only as steady as they are
   always_ff @(posedge tck) begin
      pin_meta <= pin_state;
      pin_sync <= pin_meta;
   end

   always_ff @(posedge tck or posedge tap.rst) begin
      if (tap.rst) begin
         single_bit_bypass_reg <= `SJTAP_BYPASS_CAPTURE;
      end else if (cap_dr && dr_sel == SJTAP_DR_BYPASS) begin
         single_bit_bypass_reg <= `SJTAP_BYPASS_CAPTURE;
      end else if (sh_dr && dr_sel == SJTAP_DR_BYPASS) begin
         single_bit_bypass_reg <= tdi;
      end
   end

   always_ff @(posedge tck or posedge tap.rst) begin
      if (tap.rst) begin
         id_shift <= ID_CODE;
      end else if (cap_dr && dr_sel == SJTAP_DR_ID) begin
         id_shift <= ID_CODE;
      end else if (sh_dr && dr_sel == SJTAP_DR_ID) begin
         id_shift <= {tdi, id_shift[`SJTAP_ID_LEN-1:1]};
      end
   end

   always_ff @(posedge tck or posedge tap.rst) begin
      if (tap.rst) begin
         pin_scan_chain <= '0;
      end else if (cap_dr && dr_sel == SJTAP_DR_PINS) begin
         pin_scan_chain <= pin_sync;
      end else if (sh_dr && dr_sel == SJTAP_DR_PINS) begin
         pin_scan_chain <= {tdi, pin_scan_chain[PIN_LEN:2]};
      end
   end

   // =====================================================
   // Update word and its crossing toggle
   logic [PIN_LEN:1] upd_word;
   logic upd_tgl;
   logic upd_ok;

   assign upd_ok = instr == SJTAP_I_EXTEST || instr == SJTAP_I_SAMPLE;

   always_ff @(posedge tck or posedge tap.rst) begin
      if (tap.rst) begin
         upd_word <= '0;
         upd_tgl <= 1'b0;
      end else if (en_t && tap.state == SJTAP_UPD_DR && upd_ok) begin
         upd_word <= pin_scan_chain;
         upd_tgl <= ~upd_tgl;
      end
   end

   // =====================================================
   // Serial out on the falling edge
   logic next_tdo;

   always_comb begin
      next_tdo = `SJTAP_TDO_RESET;
      if (tap.state == SJTAP_SH_IR) begin
         next_tdo = ir_shift[0];
      end else begin
         unique case (dr_sel)
            SJTAP_DR_ID: next_tdo = id_shift[0];
            SJTAP_DR_PINS: next_tdo = pin_scan_chain[1];
            default: next_tdo = single_bit_bypass_reg;
         endcase
      end
   end

   always_ff @(negedge tck or posedge tap.rst) begin
      if (tap.rst) begin
         tdo <= `SJTAP_TDO_RESET;
         tdo_oe_n <= 1'b1;
      end else if (en_t) begin
         tdo <= next_tdo;
         tdo_oe_n <= !(tap.state == SJTAP_SH_IR || tap.state == SJTAP_SH_DR);
      end
   end

   // =====================================================
   // Core domain outputs
   logic [1:0] float_sync;
   logic [1:0] ext_sync;
   logic [2:0] tgl_sync;

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         float_sync <= '0;
         ext_sync <= '0;
         tgl_sync <= '0;
      end else if (clk_en) begin
         float_sync <= {float_sync[0], instr == SJTAP_I_SAMPLE_Z};
         ext_sync <= {ext_sync[0], instr == SJTAP_I_EXTEST};
         tgl_sync <= {tgl_sync[1:0], upd_tgl};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         out_float <= 1'b0;
         extest_drive <= 1'b0;
      end else if (clk_en) begin
         out_float <= float_sync[1];
         extest_drive <= ext_sync[1];
      end
   end

   // Word stays still for many test clocks after its toggle, so it is safe here
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         pin_drive <= '0;
      end else if (clk_en && (tgl_sync[2] != tgl_sync[1])) begin
         pin_drive <= upd_word;
      end
   end

   // Mode select and serial in read high when left open; pull-ups sit at the pad.
endmodule

// File: sjtap_props.sv
`timescale 1ns/1ps
module sjtap_props #(
   parameter int PIN_LEN = 109
) (
   input wire logic sys_clk,              // Core clock
   input wire logic rst_b,                // Power-up reset
   input wire logic tck,                  // Test clock
   input wire logic tms,                  // Mode select
   input wire logic tdo,                  // Serial out
   input wire logic tdo_oe_n,             // Serial out enable
   input wire logic out_float,            // Outputs floated
   input wire logic extest_drive,         // External test
   input wire logic [PIN_LEN:1] pin_drive // Scan data to pins
);
   // ====
   // Helper: tck is still low outside frames, so any move while high is a rising launch
   logic rise_launch = 1'b0;
   always @(tdo or tdo_oe_n) begin
      if (tck && rst_b) rise_launch <= 1'b1;
   end
   sequence five_high;
      tms [*5];
   endsequence
   sequence enter_shift;
      tdo_oe_n ##1 !tdo_oe_n;
   endsequence
   // ====
   // Link side
   tms_reset_a: assert property (@(posedge tck) disable iff (!rst_b)
      five_high |=> tdo_oe_n) else $error("tdo enabled after five high tms");
   shift_entry_a: assert property (@(posedge tck) disable iff (!rst_b)
      enter_shift |-> !$past(tms, 1) && !($past(tms, 2) && $past(tms, 3)))
      else $error("tdo enabled off shift");
   shift_hold_a: assert property (@(posedge tck) disable iff (!rst_b)
      !tdo_oe_n && !tms |=> !tdo_oe_n) else $error("tdo released inside shift");
   shift_exit_a: assert property (@(posedge tck) disable iff (!rst_b)
      !tdo_oe_n && tms |=> tdo_oe_n) else $error("tdo still enabled after shift");
   // ====
   // Core side
   fall_launch_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !rise_launch) else $error("tdo changed while tck high");
   mode_excl_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !(out_float && extest_drive)) else $error("float and extest together");
   float_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      out_float && $past(out_float) |-> $stable(pin_drive)) else $error("pins moved in float");
   powerup_a: assert property (@(posedge sys_clk)
      !rst_b |=> !out_float && !extest_drive && tdo_oe_n) else $error("reset not applied");
endmodule

bind sjtap_top sjtap_props #(.PIN_LEN(PIN_LEN)) u_props (.sys_clk, .rst_b, .tck, .tms, .tdo,
   .tdo_oe_n, .out_float, .extest_drive, .pin_drive);

// File: sjtap_ctrl.sv
`timescale 1ns/1ps
module sjtap_ctrl (
   output logic tck,    // Test clock, still between frames
   output logic tms,    // Mode select
   output logic tdi,    // Serial data to the port
   input wire logic tdo // Serial data from the port
);
   // ====
   // Lines rest at their pull-up level when idle
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
   end
   task automatic step(input logic m, input logic d, output logic q);
      #1 tms = m;
      tdi = d;
      #61.5 tck = 1'b1;
      q = tdo;
      #62.5 tck = 1'b0;
   endtask
   task automatic go_idle;
      logic q;
      repeat (5) step(1'b1, 1'b1, q);
      step(1'b0, 1'b1, q);
   endtask
   task automatic scan(input bit ir, input int n, input logic [127:0] din,
         output logic [127:0] dout);
      logic q;
      dout = '0;
      step(1'b1, 1'b1, q);
      if (ir) step(1'b1, 1'b1, q);
      step(1'b0, 1'b1, q);
      step(1'b0, 1'b1, q);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], q);
         dout[i] = q;
      end
      step(1'b1, 1'b1, q);
      step(1'b0, 1'b1, q);
   endtask
   // Splits the shift with a pause so the Pause-DR and Exit2-DR arcs get exercised
   task automatic scan_pause(input int n, input logic [127:0] din, output logic [127:0] dout);
      logic q;
      dout = '0;
      step(1'b1, 1'b1, q);
      step(1'b0, 1'b1, q);
      step(1'b0, 1'b1, q);
      for (int i = 0; i < n; i++) begin
         step(i == n / 2 - 1 || i == n - 1, din[i], q);
         dout[i] = q;
         if (i == n / 2 - 1) begin
            step(1'b0, 1'b1, q);
            step(1'b0, 1'b1, q);
            step(1'b1, 1'b1, q);
            step(1'b0, 1'b1, q);
         end
      end
      step(1'b1, 1'b1, q);
      step(1'b0, 1'b1, q);
   endtask
endmodule

// File: sjtap_top_tb.sv
`timescale 1ns/1ps
module sjtap_top_tb;
   import sjtap_pkg::*;
   localparam logic [31:0] ID = 32'h3b5d_7e2f; // Arbitrary value
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [109:1] pin_state = '0;
   logic tck, tms, tdi, tdo, tdo_oe_n, out_float, extest_drive;
   logic tdo_pin;
   logic [109:1] pin_drive;
   logic [127:0] got;
   logic [2:0] codes [4] = '{3'h7, 3'h3, 3'h5, 3'h6};
   int n_errors = 0;
   int compares = 0;
   sjtap_top #(.ID_CODE(ID)) dut (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(1'b1),
      .tck(tck), .tms(tms), .tdi(tdi), .pin_state(pin_state), .tdo(tdo),
      .tdo_oe_n(tdo_oe_n), .out_float(out_float), .extest_drive(extest_drive),
      .pin_drive(pin_drive));
   // A released serial out reads as the inverse, so a late or early enable shows up
   assign tdo_pin = tdo_oe_n ? !tdo : tdo;
   sjtap_ctrl ctrl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_pin));
   initial begin
      forever #12.5 sys_clk = ~sys_clk;
   end
   // ====
   // Shared steps
   task automatic check(input logic [127:0] g, input logic [127:0] e);
      compares++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic do_reset;
      @(posedge sys_clk) #1 rst_b = 1'b0;
      repeat (16) @(posedge sys_clk);
      #1 rst_b = 1'b1;
      repeat (4) @(posedge sys_clk);
      ctrl.go_idle();
   endtask
   task automatic settle;
      repeat (8) @(posedge sys_clk);
   endtask
   task automatic conclude;
      $display("compares %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // ====
   // Scenarios
   task automatic t_idcode;
      ctrl.scan(0, 33, 128'h1, got);
      check(got[32:0], {1'b1, ID});
      check(tdo_oe_n, 1'b1);
      $display("test idcode done");
   endtask
   task automatic t_bypass;
      foreach (codes[i]) begin
         ctrl.scan(1, 3, codes[i], got);
         check(got[2:0], 3'h1);
         ctrl.scan(0, 4, 128'hd, got);
         check(got[3:0], 4'ha);
      end
      $display("test bypass done");
   endtask
   task automatic t_float;
      @(posedge sys_clk) #1 pin_state = {9'h15a, {25{4'h9}}};
      ctrl.scan(1, 3, SJTAP_I_SAMPLE_Z, got);
      settle();
      check({out_float, extest_drive}, 2'h2);
      ctrl.scan(0, 110, 128'h1, got);
      check(got[109:0], {1'b1, pin_state});
      settle();
      check(pin_drive, 109'h0);
      $display("test float done");
   endtask
   task automatic t_preload;
      ctrl.scan(1, 3, SJTAP_I_SAMPLE, got);
      ctrl.scan(0, 109, {19'h0, {27{4'h6}}, 1'b1}, got);
      settle();
      check({out_float, pin_drive}, {1'b0, {27{4'h6}}, 1'b1});
      ctrl.scan(1, 3, SJTAP_I_EXTEST, got);
      settle();
      check({out_float, extest_drive}, 2'h1);
      ctrl.scan_pause(109, {19'h0, {27{4'hc}}, 1'b0}, got);
      settle();
      check(got[108:0], pin_state);
      check(pin_drive, {{27{4'hc}}, 1'b0});
      $display("test preload done");
   endtask
   task automatic t_resets;
      ctrl.scan(1, 3, SJTAP_I_BYPASS, got);
      ctrl.go_idle();
      ctrl.scan(0, 32, 128'h0, got);
      check(got[31:0], ID);
      ctrl.scan(1, 3, SJTAP_I_EXTEST, got);
      settle();
      check(extest_drive, 1'b1);
      do_reset();
      ctrl.scan(0, 32, 128'h0, got);
      check({extest_drive, got[31:0]}, {1'b0, ID});
      $display("test resets done");
   endtask
   initial begin
      #2000000;
      n_errors++;
      conclude();
   end
   initial begin
      do_reset();
      t_idcode();
      t_bypass();
      t_float();
      t_preload();
      t_resets();
      conclude();
   end
endmodule
